// File: design/pibk_pkg.sv
// How it works
// RULE1: 64 pins, function bit picks peripheral/GPIO
// RULE2: GPIO mode bit 1 input, 0 output
// RULE3: GPIO input level latched, read from data
// RULE4: GPIO output drives written data bit
// RULE5: pin 14 dedicated is DMA request 0
// RULE6: pending flag set by event, write-one clears
// RULE7: pins 18..27 outputs pulse low on reset
// RULE8: irq, DMA req/ack, timers, serial multiplexed
// RULE9: mode regs reset F003FFFF and FFFFFFFF
// RULE10: function bit 0 dedicated, 1 GPIO
// RULE11: registers 32 bits, read back last write; interrupt mask and pending keep only 6 bits, upper bits read zero
package pibk_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_MODE_LO = 32'hF003_0000;
    localparam logic [31:0] ADDR_MODE_HI = 32'hF003_0004;
    localparam logic [31:0] ADDR_FUNC_LO = 32'hF003_0008;
    localparam logic [31:0] ADDR_FUNC_HI = 32'hF003_000C;
    localparam logic [31:0] ADDR_DMA_SEL = 32'hF003_0010;
    localparam logic [31:0] ADDR_IRQ_CFG = 32'hF003_0014;
    localparam logic [31:0] ADDR_IRQ_PND = 32'hF003_0018;
    localparam logic [31:0] ADDR_DATA_LO = 32'hF003_001C;
    localparam logic [31:0] ADDR_DATA_HI = 32'hF003_0020;
    localparam logic [31:0] ADDR_DRV_LO = 32'hF003_0024;
    localparam logic [31:0] ADDR_DRV_HI = 32'hF003_0028;
    localparam logic [31:0] ADDR_IRQ_MSK = 32'hF003_002C;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] MODE_LO_RST = 32'hF003_FFFF;
    localparam logic [31:0] MODE_HI_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] FUNC_LO_RST = 32'h0FFF_FF00;
    localparam logic [31:0] FUNC_HI_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    // data outputs idle high on the reset-pulse pins so they rise after it
    localparam logic [63:0] DATA_RST = 64'h0000_0000_0FFC_0000;
    // ------------------------------------------------------------
    // pin map of dedicated functions
    // ------------------------------------------------------------
    localparam int IRQ_BASE = 8;
    localparam int IRQ_NUM = 6;
    localparam int DREQ_BASE = 14;
    localparam int DACK_BASE = 18;
    localparam int DMA_NUM = 4;
    localparam int TMR_BASE = 22;
    localparam int TMR_NUM = 6;
    localparam logic [63:0] RST_PIN_MASK = 64'h0000_0000_0FFC_0000;
    // dma select fields: request polarity [3:0], acknowledge polarity [7:4]
    localparam int DMA_ACK_POL_POS = 4;
    localparam int HSIZE_WORD = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // external interrupt trigger, two bits per interrupt
    typedef enum logic [1:0] {TRIG_LOW, TRIG_HIGH, TRIG_FALL, TRIG_RISE} pibk_trig_t;
endpackage

// File: design/pibk_port_bank.sv
`timescale 1ns/100ps
`default_nettype none
module pibk_port_bank
    import pibk_pkg::*;
#(
    parameter int PIN_NUM = 64,
    parameter int PULSE_CYC = RST_PULSE_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins
    input wire logic [PIN_NUM-1:0] pinIn,
    output logic [PIN_NUM-1:0] pinOut,
    output logic [PIN_NUM-1:0] pinOutEn_n,
    output logic [PIN_NUM-1:0] pinDrive,
    // external reset pin
    input wire logic externalReset_n,
    // dedicated peripheral side
    input wire logic [PIN_NUM-1:0] funcOut,
    input wire logic [PIN_NUM-1:0] funcOutEn,
    output logic [PIN_NUM-1:0] funcIn,
    input wire logic [DMA_NUM-1:0] extDmaAcknowledge,
    output logic [DMA_NUM-1:0] extDmaRequest,
    input wire logic [TMR_NUM-1:0] timerOut,
    // interrupt
    output logic irqOut
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [63:0] mode_r; // 1 = input
    logic [63:0] func_r; // 1 = gpio
    logic [63:0] dataOut_r; // written output values
    logic [63:0] drive_r; // drive strength select
    logic [31:0] dmaSel_r; // dma polarity choice
    logic [31:0] irqCfg_r; // trigger per interrupt
    logic [IRQ_NUM-1:0] irqPend_r; // sticky flags
    logic [IRQ_NUM-1:0] irqPend_nxt;
    logic [IRQ_NUM-1:0] irqMask_r; // interrupt enables
    logic [63:0] pinMeta_r; // first sync stage only
    logic [63:0] pinSync_r; // second sync stage
    logic [63:0] pinLatch_r; // latched input levels
    logic [63:0] pinPrev_r; // for edge detect
    logic extRstMeta_r;
    logic extRstSync_r;
    logic [7:0] pulseCnt_r; // reset pulse length
    logic pulseActive;
    // ahb data phase state
    logic wrPend_r;
    logic [31:0] wrAddr_r;
    logic addrAccept;
    logic [31:0] rdData;
    logic [63:0] dataRead;
    logic [IRQ_NUM-1:0] irqEvent;
    logic [63:0] dedOut;
    logic [63:0] dedOe;
    // ------------------------------------------------------------
    // ahb slave
    // ------------------------------------------------------------
    // zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // only whole-word transfers are honoured; other sizes are ignored
    assign addrAccept = hsel && htrans[1] && hready && (hsize == 3'(HSIZE_WORD));

    // capture a write address phase
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= ZERO_RST;
        end
        else
        begin
            wrPend_r <= addrAccept && hwrite;
            if (addrAccept)
                wrAddr_r <= haddr;
        end
    end

    // read mux; data latched for input gpio, written value otherwise
    assign dataRead = (mode_r & func_r & pinLatch_r) | (~(mode_r & func_r) & dataOut_r); // RULE3
    always_comb
    begin
        if (haddr == ADDR_MODE_LO)
            rdData = mode_r[31:0]; // RULE11
        else if (haddr == ADDR_MODE_HI)
            rdData = mode_r[63:32];
        else if (haddr == ADDR_FUNC_LO)
            rdData = func_r[31:0];
        else if (haddr == ADDR_FUNC_HI)
            rdData = func_r[63:32];
        else if (haddr == ADDR_DMA_SEL)
            rdData = dmaSel_r;
        else if (haddr == ADDR_IRQ_CFG)
            rdData = irqCfg_r;
        else if (haddr == ADDR_IRQ_PND)
            rdData = {26'h0, irqPend_r};
        else if (haddr == ADDR_DATA_LO)
            rdData = dataRead[31:0];
        else if (haddr == ADDR_DATA_HI)
            rdData = dataRead[63:32];
        else if (haddr == ADDR_DRV_LO)
            rdData = drive_r[31:0];
        else if (haddr == ADDR_DRV_HI)
            rdData = drive_r[63:32];
        else if (haddr == ADDR_IRQ_MSK)
            rdData = {26'h0, irqMask_r};
        else
            rdData = 32'h0000_0000; // unmapped reads zero
    end

    // read data sampled at the address phase, shown in the data phase
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            hrdata <= ZERO_RST;
        else if (addrAccept && !hwrite)
            hrdata <= rdData;
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            mode_r <= {MODE_HI_RST, MODE_LO_RST}; // RULE9
            func_r <= {FUNC_HI_RST, FUNC_LO_RST};
            drive_r <= {ZERO_RST, ZERO_RST};
            dmaSel_r <= ZERO_RST;
            irqCfg_r <= ZERO_RST;
            irqMask_r <= '0;
            dataOut_r <= DATA_RST;
        end
        else if (wrPend_r)
        begin
            // unmapped writes fall through and are dropped
            if (wrAddr_r == ADDR_MODE_LO)
                mode_r[31:0] <= hwdata; // RULE2
            else if (wrAddr_r == ADDR_MODE_HI)
                mode_r[63:32] <= hwdata;
            else if (wrAddr_r == ADDR_FUNC_LO)
                func_r[31:0] <= hwdata; // RULE1
            else if (wrAddr_r == ADDR_FUNC_HI)
                func_r[63:32] <= hwdata;
            else if (wrAddr_r == ADDR_DMA_SEL)
                dmaSel_r <= hwdata;
            else if (wrAddr_r == ADDR_IRQ_CFG)
                irqCfg_r <= hwdata;
            else if (wrAddr_r == ADDR_DATA_LO)
                dataOut_r[31:0] <= hwdata; // RULE4
            else if (wrAddr_r == ADDR_DATA_HI)
                dataOut_r[63:32] <= hwdata;
            else if (wrAddr_r == ADDR_DRV_LO)
                drive_r[31:0] <= hwdata;
            else if (wrAddr_r == ADDR_DRV_HI)
                drive_r[63:32] <= hwdata;
            else if (wrAddr_r == ADDR_IRQ_MSK)
                irqMask_r <= hwdata[IRQ_NUM-1:0];
        end
    end
    assign pinDrive = drive_r;

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    // two flops before any logic; latch kept per pin for reads
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
            pinLatch_r <= '0;
            pinPrev_r <= '0;
            extRstMeta_r <= 1'b1;
            extRstSync_r <= 1'b1;
        end
        else
        begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
            pinLatch_r <= pinSync_r; // RULE3
            pinPrev_r <= pinSync_r;
            extRstMeta_r <= externalReset_n;
            extRstSync_r <= extRstMeta_r;
        end
    end
    assign funcIn = pinSync_r;

    // ------------------------------------------------------------
    // reset pulse on pins 18..27
    // ------------------------------------------------------------
    // counter reloads during system or external reset, so the pins
    // stay low through reset and for a fixed time after release
    always_ff @(posedge clk)
    begin
        if (!reset_n || !extRstSync_r)
            pulseCnt_r <= 8'(PULSE_CYC); // RULE7
        else if (pulseCnt_r != 8'h00)
            pulseCnt_r <= pulseCnt_r - 8'h01;
    end
    assign pulseActive = (pulseCnt_r != 8'h00);

    // ------------------------------------------------------------
    // dedicated function map
    // ------------------------------------------------------------
    always_comb
    begin
        dedOut = funcOut; // serial link and others pass through
        dedOe = funcOutEn;
        // irq and dma request pins are inputs when dedicated
        dedOe[IRQ_BASE +: IRQ_NUM] = '0; // RULE8
        dedOe[DREQ_BASE +: DMA_NUM] = '0;
        dedOut[DACK_BASE +: DMA_NUM] = extDmaAcknowledge ^ dmaSel_r[DMA_ACK_POL_POS +: DMA_NUM];
        dedOe[DACK_BASE +: DMA_NUM] = '1;
        dedOut[TMR_BASE +: TMR_NUM] = timerOut;
        dedOe[TMR_BASE +: TMR_NUM] = '1;
    end

    // request polarity set per line in the dma select register
    assign extDmaRequest = pinSync_r[DREQ_BASE +: DMA_NUM] ^ dmaSel_r[DMA_NUM-1:0]; // RULE5

    // per pin output mux
    genvar gi;
    generate
        for (gi = 0; gi < PIN_NUM; gi++)
        begin : g_pin
            logic gpioOut;
            assign gpioOut = func_r[gi] && !mode_r[gi]; // RULE10
            always_comb
            begin
                if (func_r[gi])
                begin
                    pinOutEn_n[gi] = !gpioOut; // RULE2
                    if (RST_PIN_MASK[gi] && pulseActive)
                        pinOut[gi] = 1'b0; // RULE7
                    else
                        pinOut[gi] = dataOut_r[gi]; // RULE4
                end
                else
                begin
                    pinOutEn_n[gi] = !dedOe[gi]; // RULE1
                    pinOut[gi] = dedOut[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // external interrupts
    // ------------------------------------------------------------
    // events only count while the pin holds its interrupt function
    always_comb
    begin
        for (int i = 0; i < IRQ_NUM; i++)
        begin
            case (pibk_trig_t'(irqCfg_r[2*i +: 2]))
                TRIG_LOW: irqEvent[i] = !pinSync_r[IRQ_BASE+i];
                TRIG_HIGH: irqEvent[i] = pinSync_r[IRQ_BASE+i];
                TRIG_FALL: irqEvent[i] = pinPrev_r[IRQ_BASE+i] && !pinSync_r[IRQ_BASE+i];
                default: irqEvent[i] = !pinPrev_r[IRQ_BASE+i] && pinSync_r[IRQ_BASE+i];
            endcase
            irqEvent[i] = irqEvent[i] && !func_r[IRQ_BASE+i];
        end
    end

    // write one clears; a new event in the same cycle wins
    always_comb
    begin
        irqPend_nxt = irqPend_r;
        if (wrPend_r && wrAddr_r == ADDR_IRQ_PND)
            irqPend_nxt = irqPend_r & ~hwdata[IRQ_NUM-1:0];
        irqPend_nxt = irqPend_nxt | irqEvent; // RULE6
    end
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            irqPend_r <= '0;
        else
            irqPend_r <= irqPend_nxt;
    end
    assign irqOut = |(irqPend_r & irqMask_r);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pend_clear;
        @(posedge clk) disable iff (!reset_n)
        (wrPend_r && wrAddr_r == ADDR_IRQ_PND && hwdata[0] && !irqEvent[0]) |=> !irqPend_r[0];
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared"); // RULE6
    property p_pend_sticky;
        @(posedge clk) disable iff (!reset_n)
        (irqPend_r[0] && !(wrPend_r && wrAddr_r == ADDR_IRQ_PND)) |=> irqPend_r[0];
    endproperty
    a_pend_sticky: assert property (p_pend_sticky) else $error("pending lost"); // RULE6
    property p_irq_out;
        @(posedge clk) disable iff (!reset_n)
        (irqEvent[0] && irqMask_r[0] && !(wrPend_r && wrAddr_r == ADDR_IRQ_MSK)) |=> irqOut;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq not raised"); // RULE6
    property p_rst_low;
        @(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> pulseActive[*8];
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset pulse short"); // RULE7
    property p_rst_pin;
        @(posedge clk) disable iff (!reset_n)
        (pulseActive && func_r[20] && !mode_r[20]) |-> (!pinOut[20] && !pinOutEn_n[20]);
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin not low"); // RULE7
    property p_mode_rst;
        @(posedge clk) $rose(reset_n) |-> (mode_r == {MODE_HI_RST, MODE_LO_RST});
    endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode reset value"); // RULE9
    property p_gpio_out;
        @(posedge clk) disable iff (!reset_n)
        (func_r[3] && !mode_r[3]) |-> (!pinOutEn_n[3] && pinOut[3] == dataOut_r[3]);
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong"); // RULE4
    property p_gpio_in;
        @(posedge clk) disable iff (!reset_n)
        (func_r[40] && mode_r[40]) |-> pinOutEn_n[40];
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("gpio input driven"); // RULE2
    property p_read_latch;
        @(posedge clk) disable iff (!reset_n)
        (addrAccept && !hwrite && haddr == ADDR_DATA_LO && func_r[20] && mode_r[20])
            |=> hrdata[20] == $past(pinLatch_r[20]);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("data read wrong"); // RULE3
    property p_dma_req;
        @(posedge clk) disable iff (!reset_n)
        !func_r[14] |-> extDmaRequest[0] == (pinSync_r[14] ^ dmaSel_r[0]);
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("dma request wrong"); // RULE5
    property p_func_sel;
        @(posedge clk) disable iff (!reset_n)
        !func_r[30] |-> (pinOut[30] == funcOut[30] && pinOutEn_n[30] == !funcOutEn[30]);
    endproperty
    a_func_sel: assert property (p_func_sel) else $error("dedicated mux wrong"); // RULE10
    property p_wr_back;
        @(posedge clk) disable iff (!reset_n)
        (addrAccept && hwrite && haddr == ADDR_FUNC_LO) |=> ##1 func_r[31:0] == $past(hwdata);
    endproperty
    a_wr_back: assert property (p_wr_back) else $error("write lost"); // RULE11
    c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irqOut));
    c_clear: cover property (@(posedge clk) disable iff (!reset_n) $fell(irqPend_r[0]));
    c_pulse_end: cover property (@(posedge clk) disable iff (!reset_n) $fell(pulseActive));
endmodule // pibk_port_bank
`default_nettype wire

// File: tb/pibk_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// parts wired to the pins
// ----------------------------------------
module pibk_pin_model
(
    // clock
    input wire logic clk,
    // device side of the pins
    input wire logic [63:0] pinOut,
    input wire logic [63:0] pinOutEn_n,
    // what the attached parts drive
    input wire logic [63:0] extVal,
    input wire logic [63:0] extEn,
    // resolved pin level
    output logic [63:0] pinLevel
);
    // no pull-ups: a floating pin flips every cycle, so no stale level
    logic [63:0] float_r = 64'h5555_5555_5555_5555;
    // flips the floating pattern
    always @(posedge clk)
    begin
        float_r <= ~float_r;
    end
    // device drive first, then attached part, else float
    assign pinLevel = (~pinOutEn_n & pinOut) | (pinOutEn_n & extEn & extVal)
        | (pinOutEn_n & ~extEn & float_r);
endmodule // pibk_pin_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import pibk_pkg::*;
;
    // short reset pulse keeps the run brief
    localparam int PULSE = 8;
    // ----------------------------------------
    // stimulus and wires
    // ----------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic extRst_n = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] dmaAck = 4'h0;
    logic [5:0] tmrOut = 6'h00;
    logic [63:0] fOut = 64'h0, fOutEn = 64'h0, extVal = 64'h0, extEn = 64'h0;
    wire logic hreadyOut, hresp, irqOut;
    wire logic [31:0] hrdata;
    wire logic [3:0] dmaReq;
    wire logic [63:0] pinOut, pinOutEn_n, pinDrive, funcIn, pinLevel;
    int err_total = 0, checked = 0, cyc = 0;
    // register rows: address, reset value, write, read back
    typedef struct {logic [31:0] a, rst, wd, rb;} pibk_row_t;
    pibk_row_t rows [11] = '{
        '{ADDR_IRQ_PND, ZERO_RST, 32'hFFFF_FFFF, 32'h0000_0000},
        '{ADDR_MODE_HI, MODE_HI_RST, 32'h1234_5678, 32'h1234_5678},
        '{ADDR_FUNC_HI, FUNC_HI_RST, 32'h8765_4321, 32'h8765_4321},
        '{ADDR_DMA_SEL, ZERO_RST, 32'h5A5A_00A5, 32'h5A5A_00A5},
        '{ADDR_IRQ_CFG, ZERO_RST, 32'h0000_0FFF, 32'h0000_0FFF},
        '{ADDR_DRV_LO, ZERO_RST, 32'hCAFE_F00D, 32'hCAFE_F00D},
        '{ADDR_DRV_HI, ZERO_RST, 32'h0F0F_0F0F, 32'h0F0F_0F0F},
        '{ADDR_IRQ_MSK, ZERO_RST, 32'h0000_003F, 32'h0000_003F},
        '{ADDR_FUNC_LO, FUNC_LO_RST, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
        '{ADDR_MODE_LO, MODE_LO_RST, 32'hFFFF_0000, 32'hFFFF_0000},
        '{32'hF003_0030, ZERO_RST, 32'h1234_5678, 32'h0000_0000}
    };
    // device and pin partner
    pibk_port_bank #(.PIN_NUM(64), .PULSE_CYC(PULSE)) i_dut (.clk(clk),
        .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyOut),
        .hreadyout(hreadyOut), .hresp(hresp), .hrdata(hrdata), .pinIn(pinLevel),
        .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .pinDrive(pinDrive),
        .externalReset_n(extRst_n), .funcOut(fOut), .funcOutEn(fOutEn),
        .funcIn(funcIn), .extDmaAcknowledge(dmaAck), .extDmaRequest(dmaReq),
        .timerOut(tmrOut), .irqOut(irqOut));
    pibk_pin_model i_pins (.clk(clk), .pinOut(pinOut), .pinOutEn_n(pinOutEn_n),
        .extVal(extVal), .extEn(extEn), .pinLevel(pinLevel));
    // ----------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------
    always #20 clk = ~clk;
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask
    // lets outputs settle off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one single word transfer; waits on hready, never a fixed count
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyOut !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyOut !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(nm, 64'(e), 64'(x));
    endtask
    // pins 18..27 low now, high again after about the pulse length
    task automatic pulse_chk();
        int n;
        n = 0;
        chk("pulse low", 64'h0, 64'(pinOut[27:18]));
        while (pinOut[27:18] !== 10'h3FF && n < 60)
        begin
            settle(1);
            n++;
        end
        chk("pulse len", 64'h1, 64'(n >= PULSE - 3 && n <= PULSE + 3));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        settle(1);
        pulse_chk();
        // external reset pin reaches the pins only
        @(posedge clk);
        extRst_n <= 1'b0;
        repeat (3) @(posedge clk);
        extRst_n <= 1'b1;
        settle(3);
        pulse_chk();
        tend("reset pulse");
        // table loop, unmapped row last
        foreach (rows[i])
        begin
            rdchk("reset value", rows[i].a, rows[i].rst);
            wr(rows[i].a, rows[i].wd);
            rdchk("read back", rows[i].a, rows[i].rb);
        end
        chk("drive", 64'h0F0F_0F0F_CAFE_F00D, pinDrive);
        chk("okay", 64'h0, 64'(hresp));
        tend("register table");
        // general purpose both words, inputs driven by the partner
        extEn <= 64'h0000_FFFF_FFFF_0000;
        extVal <= 64'h0000_1357_BEEF_0000;
        wr(ADDR_DATA_LO, 32'h0000_5A3C);
        wr(ADDR_FUNC_HI, 32'hFFFF_FFFF);
        wr(ADDR_MODE_HI, 32'h0000_FFFF);
        wr(ADDR_DATA_HI, 32'h2468_0000);
        settle(4);
        chk("out lo", 64'h5A3C, 64'(pinOut[15:0]));
        chk("out hi", 64'h2468, 64'(pinOut[63:48]));
        chk("dir", 64'h0000_FFFF_FFFF_0000, pinOutEn_n);
        rdchk("in lo", ADDR_DATA_LO, 32'hBEEF_5A3C);
        rdchk("in hi", ADDR_DATA_HI, 32'h2468_1357);
        tend("gpio");
        // dedicated: pin 0 passthrough, dma req 14, ack 18, timer 22
        fOut <= 64'h1;
        fOutEn <= 64'h1;
        dmaAck <= 4'h1;
        tmrOut <= 6'h01;
        extEn <= 64'h4000;
        extVal <= 64'h4000;
        wr(ADDR_MODE_LO, 32'hFFFF_FFFF);
        wr(ADDR_DMA_SEL, 32'h0000_0000);
        wr(ADDR_FUNC_LO, 32'hFFBB_BFFE);
        settle(4);
        chk("func pin", 64'h1, 64'(pinOut[0] & ~pinOutEn_n[0]));
        chk("ack pin", 64'h1, 64'(pinOut[18]));
        chk("timer pin", 64'h1, 64'(pinOut[22]));
        chk("dma req", 64'h1, 64'(dmaReq[0]));
        chk("func in", 64'h1, 64'(funcIn[14]));
        wr(ADDR_DMA_SEL, 32'h0000_0011);
        settle(4);
        chk("dma req inv", 64'h0, 64'(dmaReq[0]));
        chk("ack inv", 64'h0, 64'(pinOut[18]));
        tend("dedicated");
        // interrupt 0 on pin 8: raise, write zero, clear, masked
        @(posedge clk);
        extEn <= 64'h0100;
        extVal <= 64'h0;
        wr(ADDR_IRQ_CFG, 32'h0000_0003);
        wr(ADDR_IRQ_MSK, 32'h0000_0001);
        wr(ADDR_FUNC_LO, 32'hFFFF_FEFF);
        wr(ADDR_IRQ_PND, 32'hFFFF_FFFF);
        rdchk("no event", ADDR_IRQ_PND, 32'h0000_0000);
        extVal <= 64'h0100;
        settle(6);
        chk("irq on", 64'h1, 64'(irqOut));
        rdchk("pending", ADDR_IRQ_PND, 32'h0000_0001);
        wr(ADDR_IRQ_PND, 32'h0000_0000);
        rdchk("write zero", ADDR_IRQ_PND, 32'h0000_0001);
        wr(ADDR_IRQ_PND, 32'h0000_0001);
        rdchk("cleared", ADDR_IRQ_PND, 32'h0000_0000);
        chk("irq off", 64'h0, 64'(irqOut));
        wr(ADDR_IRQ_MSK, 32'h0000_0000);
        wr(ADDR_IRQ_CFG, 32'h0000_0002);
        extVal <= 64'h0;
        settle(6);
        chk("masked", 64'h0, 64'(irqOut));
        rdchk("masked pend", ADDR_IRQ_PND, 32'h0000_0001);
        // level triggers: low level keeps the flag set through a clear
        wr(ADDR_IRQ_CFG, 32'h0000_0000);
        wr(ADDR_IRQ_PND, 32'h0000_0001);
        rdchk("low level", ADDR_IRQ_PND, 32'h0000_0001);
        wr(ADDR_IRQ_CFG, 32'h0000_0001);
        wr(ADDR_IRQ_PND, 32'h0000_0001);
        rdchk("high idle", ADDR_IRQ_PND, 32'h0000_0000);
        tend("interrupt");
        // reset again in mid-run
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        settle(1);
        pulse_chk();
        rdchk("second reset", ADDR_MODE_LO, MODE_LO_RST);
        tend("second reset");
        finish_test();
    end
endmodule // tb
`default_nettype wire
